// File: duc_core.sv
// Converter control core: code registers, load and clear sequencing, fault pin
//
// Notes on behaviour
// - Command 0x05 loads output, data ignored.
// - Load copies input code to output code.
// - 0x03/0x07 input, 0x04/0x08 output register access.
// - 0x06 writes, 0x09 reads clear value.
// - 0x0F and 0x00 are no-operations.
// - Input code resets zero, midscale if bipolar.
// - Output code always resets to zero.
// - Clear value resets zero, midscale if bipolar.
// - Trim: bit15 enable, bit9 straight, 8-0 inverted.
// - Trim value 0 low, 511/512 zero, 1023 high.
// - Trim write shares clear code; code configurable.
// - Load pin low keeps input transparent.
// - Clear pin enters clear; source by mode bit.
// - Zero state is code zero, analog maps it.
// - Clear-disable bit makes pin ignored.
// - Clear status reads one while clearing.
// - Remain-in-clear exits need pin high plus event.
// - Without remain-in-clear, disable or pin high exits.
// - Alarm pin is open-drain, active low.
// - Alarm on fault when fault report enabled.
// - Alarm on clear state when flag enabled.
// - Short and open flags readable in control.
// - Control bit positions 9 down to 2.
`timescale 1ns/100ps
module duc_core #(
    parameter logic [7:0] TRIM_CMD = duc_pkg::CMD_WR_TRIM_DEFAULT
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CMD_VALID_IN,
    input wire logic [7:0] CMD_CODE_IN,
    input wire logic [15:0] CMD_DATA_IN,
    input wire logic BIPOLAR_IN,
    input wire logic LOAD_STROBE_N_IN,
    input wire logic ASYNC_CLEAR_N_IN,
    input wire logic VOUT_SHORT_IN,
    input wire logic IOUT_OPEN_IN,
    output logic [15:0] READ_DATA_OUT,
    output logic READ_VALID_OUT,
    output logic [15:0] ACTIVE_CODE_OUT,
    output logic ZERO_STATE_OUT,
    output logic [15:0] OUTPUT_CODE_OUT,
    output logic TRIM_ENABLE_OUT,
    output logic [9:0] TRIM_VALUE_OUT,
    output logic FAULT_OUT,
    output logic FAULT_OE_OUT
);
    // Trim bits to linear value: top bit straight, rest inverted
    function automatic logic [9:0] trim_linear(input logic [15:0] raw);
        trim_linear = {raw[duc_pkg::TRIM_MSB], raw[8:0] ^ duc_pkg::TRIM_LOW_INV};
    endfunction : trim_linear

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [2:0] ld_sync_reg;
    logic [2:0] cl_sync_reg;
    logic [2:0] vs_sync_reg;
    logic [2:0] io_sync_reg;
    logic ld_low_reg;
    logic cl_low_reg;
    logic vshort_reg;
    logic iopen_reg;
    logic init_reg;
    logic [15:0] input_code_reg;
    logic [15:0] output_code_reg;
    logic [15:0] clear_code_reg;
    logic trim_en_reg;
    logic [9:0] trim_value_reg;
    logic fault_pin_reg;
    duc_pkg::duc_ctrl_t ctrl_reg;
    duc_pkg::duc_ctrl_t ctrl_next;
    duc_pkg::duc_state_t state_reg;
    duc_pkg::duc_state_t state_next;
    logic [15:0] read_data_reg;
    logic read_valid_reg;
    logic [15:0] active_reg;
    logic zero_reg;
    logic fault_reg;

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Three stages; a level counts only once stages two and three agree
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ld_sync_reg <= duc_pkg::SYNC_INIT;
        end else begin
            ld_sync_reg <= {ld_sync_reg[1:0], LOAD_STROBE_N_IN};
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            cl_sync_reg <= duc_pkg::SYNC_INIT;
        end else begin
            cl_sync_reg <= {cl_sync_reg[1:0], ASYNC_CLEAR_N_IN};
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            vs_sync_reg <= 3'h0;
        end else begin
            vs_sync_reg <= {vs_sync_reg[1:0], VOUT_SHORT_IN};
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            io_sync_reg <= 3'h0;
        end else begin
            io_sync_reg <= {io_sync_reg[1:0], IOUT_OPEN_IN};
        end
    end

    // Idle levels at reset, so release never looks like a pin event
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ld_low_reg <= 1'b0;
        end else if (ld_sync_reg[1] == ld_sync_reg[2]) begin
            ld_low_reg <= ~ld_sync_reg[2];
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            cl_low_reg <= 1'b0;
        end else if (cl_sync_reg[1] == cl_sync_reg[2]) begin
            cl_low_reg <= ~cl_sync_reg[2];
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            vshort_reg <= 1'b0;
        end else if (vs_sync_reg[1] == vs_sync_reg[2]) begin
            vshort_reg <= vs_sync_reg[2];
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            iopen_reg <= 1'b0;
        end else if (io_sync_reg[1] == io_sync_reg[2]) begin
            iopen_reg <= io_sync_reg[2];
        end
    end

    // Command decode
    wire wr_input = CMD_VALID_IN && CMD_CODE_IN == duc_pkg::CMD_WR_INPUT;
    wire wr_output = CMD_VALID_IN && CMD_CODE_IN == duc_pkg::CMD_WR_OUTPUT;
    wire cmd_load = CMD_VALID_IN && CMD_CODE_IN == duc_pkg::CMD_LOAD;
    wire wr_clear = CMD_VALID_IN && CMD_CODE_IN == duc_pkg::CMD_WR_CLEAR;
    wire wr_trim = CMD_VALID_IN && CMD_CODE_IN == TRIM_CMD;
    wire wr_ctrl = CMD_VALID_IN && CMD_CODE_IN == duc_pkg::CMD_WR_CTRL;
    wire rd_input = CMD_CODE_IN == duc_pkg::CMD_RD_INPUT;
    wire rd_output = CMD_CODE_IN == duc_pkg::CMD_RD_OUTPUT;
    wire rd_clear = CMD_CODE_IN == duc_pkg::CMD_RD_CLEAR;
    wire rd_ctrl = CMD_CODE_IN == duc_pkg::CMD_RD_CTRL;
    // No-op and unknown codes read back whatever was last shifted
    wire is_nop = CMD_CODE_IN == duc_pkg::CMD_NOP0 || CMD_CODE_IN == duc_pkg::CMD_NOP1;
    wire load_evt = cmd_load || ld_low_reg;
    wire in_clear = state_reg != duc_pkg::DUC_RUN;
    wire [15:0] ctrl_word = {6'h00, ctrl_reg.clr_dis, ctrl_reg.clr_src, ctrl_reg.remain_in_clear,
                             ctrl_reg.flt_en, ctrl_reg.cflg_en, vshort_reg, iopen_reg,
                             in_clear, 2'h0};
    wire [15:0] rd_mux = rd_input ? input_code_reg :
                         rd_output ? output_code_reg :
                         rd_clear ? clear_code_reg :
                         rd_ctrl ? ctrl_word : read_data_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next.clr_dis = CMD_DATA_IN[duc_pkg::BIT_CLR_DIS];
            ctrl_next.clr_src = CMD_DATA_IN[duc_pkg::BIT_CLR_SRC];
            ctrl_next.remain_in_clear = CMD_DATA_IN[duc_pkg::BIT_REMAIN_IN_CLEAR];
            ctrl_next.flt_en = CMD_DATA_IN[duc_pkg::BIT_FLT_EN];
            ctrl_next.cflg_en = CMD_DATA_IN[duc_pkg::BIT_CFLG_EN];
        end
    end

    // Clear state: DUC_CLEAR while pin held, DUC_HOLD once pin released under remain
    wire pin_act = cl_low_reg && !ctrl_next.clr_dis;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            duc_pkg::DUC_RUN: begin
                if (pin_act) state_next = duc_pkg::DUC_CLEAR;
            end
            duc_pkg::DUC_CLEAR: begin
                if (ctrl_next.clr_dis && !ctrl_reg.remain_in_clear) state_next = duc_pkg::DUC_RUN;
                else if (!cl_low_reg) state_next = ctrl_reg.remain_in_clear ? duc_pkg::DUC_HOLD
                                                                  : duc_pkg::DUC_RUN;
            end
            duc_pkg::DUC_HOLD: begin
                if (pin_act) state_next = duc_pkg::DUC_CLEAR;
                else if (wr_output || load_evt || !ctrl_next.remain_in_clear) state_next = duc_pkg::DUC_RUN;
            end
            default: state_next = duc_pkg::DUC_RUN;
        endcase
    end

    wire [15:0] out_next = wr_output ? CMD_DATA_IN : load_evt ? input_code_reg
                           : output_code_reg;
    wire next_clear = state_next != duc_pkg::DUC_RUN;
    wire [15:0] active_next = !next_clear ? out_next :
                              ctrl_next.clr_src ? clear_code_reg : duc_pkg::CODE_ZERO;
    wire fault_next = (ctrl_next.flt_en && (vshort_reg || iopen_reg)) ||
                      (ctrl_next.cflg_en && next_clear);

    // Bipolar strap caught on the first clocked edge after release
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            init_reg <= 1'b1;
            input_code_reg <= duc_pkg::CODE_ZERO;
            clear_code_reg <= duc_pkg::CODE_ZERO;
        end else begin
            init_reg <= 1'b0;
            if (init_reg) begin
                input_code_reg <= BIPOLAR_IN ? duc_pkg::CODE_MID : duc_pkg::CODE_ZERO;
                clear_code_reg <= BIPOLAR_IN ? duc_pkg::CODE_MID : duc_pkg::CODE_ZERO;
            end else begin
                if (wr_input) input_code_reg <= CMD_DATA_IN;
                if (wr_clear) clear_code_reg <= CMD_DATA_IN;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            output_code_reg <= duc_pkg::CODE_ZERO;
        end else begin
            output_code_reg <= out_next;
        end
    end

    // Trim kept in its linear form so the output leaves a flop directly
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            trim_en_reg <= 1'b0;
            trim_value_reg <= 10'h000;
        end else if (wr_trim) begin
            trim_en_reg <= CMD_DATA_IN[duc_pkg::BIT_TRIM_EN];
            trim_value_reg <= trim_linear(CMD_DATA_IN);
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= duc_pkg::DUC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            read_data_reg <= duc_pkg::CODE_ZERO;
            read_valid_reg <= 1'b0;
        end else begin
            read_valid_reg <= CMD_VALID_IN;
            if (CMD_VALID_IN && !is_nop) begin
                read_data_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= duc_pkg::CODE_ZERO;
        end else begin
            active_reg <= active_next;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            zero_reg <= 1'b0;
        end else begin
            zero_reg <= next_clear && !ctrl_next.clr_src;
        end
    end

    // Open drain: level flop stays low, enable flop carries the alarm
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            fault_reg <= 1'b0;
            fault_pin_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
            fault_pin_reg <= 1'b0;
        end
    end

    assign READ_DATA_OUT = read_data_reg;
    assign READ_VALID_OUT = read_valid_reg;
    assign ACTIVE_CODE_OUT = active_reg;
    assign ZERO_STATE_OUT = zero_reg;
    assign OUTPUT_CODE_OUT = output_code_reg;
    assign TRIM_ENABLE_OUT = trim_en_reg;
    assign TRIM_VALUE_OUT = trim_value_reg;
    assign FAULT_OUT = fault_pin_reg;
    assign FAULT_OE_OUT = fault_reg;
endmodule : duc_core

// File: duc_pkg.sv
// Package of command codes, control field positions and reset values for the converter core
package duc_pkg;
    localparam int CODE_W = 16;
    localparam logic [7:0] CMD_NOP0 = 8'h00;
    localparam logic [7:0] CMD_WR_INPUT = 8'h03;
    localparam logic [7:0] CMD_WR_OUTPUT = 8'h04;
    localparam logic [7:0] CMD_LOAD = 8'h05;
    localparam logic [7:0] CMD_WR_CLEAR = 8'h06;
    localparam logic [7:0] CMD_RD_INPUT = 8'h07;
    localparam logic [7:0] CMD_RD_OUTPUT = 8'h08;
    localparam logic [7:0] CMD_RD_CLEAR = 8'h09;
    localparam logic [7:0] CMD_NOP1 = 8'h0F;
    // Trim write shares the clear write code; a separate code is a parameter of the top
    localparam logic [7:0] CMD_WR_TRIM_DEFAULT = 8'h06;
    localparam logic [7:0] CMD_WR_CTRL = 8'h01;
    localparam logic [7:0] CMD_RD_CTRL = 8'h02;
    localparam int BIT_CLR_DIS = 9;
    localparam int BIT_CLR_SRC = 8;
    localparam int BIT_REMAIN_IN_CLEAR = 7;
    localparam int BIT_FLT_EN = 6;
    localparam int BIT_CFLG_EN = 5;
    localparam int BIT_VSHORT = 4;
    localparam int BIT_IOPEN = 3;
    localparam int BIT_CLRST = 2;
    localparam int BIT_TRIM_EN = 15;
    localparam int TRIM_MSB = 9;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;
    localparam logic [8:0] TRIM_LOW_INV = 9'h1FF;
    localparam logic [2:0] SYNC_INIT = 3'h7;
    typedef struct packed {
        logic clr_dis;
        logic clr_src;
        logic remain_in_clear;
        logic flt_en;
        logic cflg_en;
    } duc_ctrl_t;
    typedef enum logic [1:0] {
        DUC_RUN = 2'b00,
        DUC_CLEAR = 2'b01,
        DUC_HOLD = 2'b11
    } duc_state_t;
endpackage : duc_pkg

// File: duc_core_sva.sv
// Port-level checker for the converter core
`timescale 1ns/100ps
module duc_core_sva #(
    parameter logic [7:0] TRIM_CMD = duc_pkg::CMD_WR_TRIM_DEFAULT
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CMD_VALID_IN,
    input wire logic [7:0] CMD_CODE_IN,
    input wire logic [15:0] CMD_DATA_IN,
    input wire logic BIPOLAR_IN,
    input wire logic LOAD_STROBE_N_IN,
    input wire logic ASYNC_CLEAR_N_IN,
    input wire logic VOUT_SHORT_IN,
    input wire logic IOUT_OPEN_IN,
    input wire logic [15:0] READ_DATA_OUT,
    input wire logic READ_VALID_OUT,
    input wire logic [15:0] ACTIVE_CODE_OUT,
    input wire logic ZERO_STATE_OUT,
    input wire logic [15:0] OUTPUT_CODE_OUT,
    input wire logic TRIM_ENABLE_OUT,
    input wire logic [9:0] TRIM_VALUE_OUT,
    input wire logic FAULT_OUT,
    input wire logic FAULT_OE_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Write and no-op codes leave the readback untouched
    wire keep_rd = CMD_VALID_IN &&
        (CMD_CODE_IN inside {8'h00, 8'h0F, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, TRIM_CMD});
    wire is_cmd = CMD_VALID_IN;
    AST_READ_PULSE: assert property (is_cmd |=> READ_VALID_OUT)
        else $error("readback strobe missing");
    AST_READ_IDLE: assert property (!is_cmd |=> !READ_VALID_OUT)
        else $error("stray readback strobe");
    AST_WR_OUTPUT: assert property (is_cmd && CMD_CODE_IN == 8'h04
        |=> OUTPUT_CODE_OUT == $past(CMD_DATA_IN)) else $error("output code not written");
    AST_RD_OUTPUT: assert property (is_cmd && CMD_CODE_IN == 8'h08
        |=> READ_DATA_OUT == $past(OUTPUT_CODE_OUT)) else $error("output code readback");
    AST_KEEP_READBACK: assert property (keep_rd |=> $stable(READ_DATA_OUT))
        else $error("readback changed on non-read");
    AST_TRIM: assert property (is_cmd && CMD_CODE_IN == TRIM_CMD |=>
        {TRIM_ENABLE_OUT, TRIM_VALUE_OUT} == {$past(CMD_DATA_IN[15]), $past(CMD_DATA_IN[9]),
        ~$past(CMD_DATA_IN[8:0])}) else $error("trim register mapping");
    AST_FAULT_LEVEL: assert property (FAULT_OUT == 1'b0)
        else $error("alarm pin level not low");
    AST_ZERO_CODE: assert property (ZERO_STATE_OUT |-> ACTIVE_CODE_OUT == 16'h0000)
        else $error("zero state code");
endmodule : duc_core_sva
bind duc_core duc_core_sva #(.TRIM_CMD(TRIM_CMD)) u_sva (.CORE_CLK_IN, .RST_N_IN,
    .CMD_VALID_IN, .CMD_CODE_IN, .CMD_DATA_IN, .BIPOLAR_IN, .LOAD_STROBE_N_IN,
    .ASYNC_CLEAR_N_IN, .VOUT_SHORT_IN, .IOUT_OPEN_IN, .READ_DATA_OUT, .READ_VALID_OUT,
    .ACTIVE_CODE_OUT, .ZERO_STATE_OUT, .OUTPUT_CODE_OUT, .TRIM_ENABLE_OUT,
    .TRIM_VALUE_OUT, .FAULT_OUT, .FAULT_OE_OUT);

// File: duc_host_model.sv
// Host model: command issue and load/clear pin drive
`timescale 1ns/100ps
module duc_host_model (
    input wire logic clk_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_code_out,
    output logic [15:0] cmd_data_out,
    output logic load_n_out,
    output logic clear_n_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 8'h00;
        cmd_data_out = 16'h0000;
        load_n_out = 1'b1;
        clear_n_out = 1'b1;
    end
    task automatic send(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_code_out = code;
        cmd_data_out = data;
        @(negedge clk_in);
        cmd_valid_out = 1'b0;
        // Stale word inverted so it is never taken for fresh data
        cmd_data_out = ~data;
    endtask : send
    task automatic pins(input logic load_n, input logic clear_n);
        @(negedge clk_in);
        load_n_out = load_n;
        clear_n_out = clear_n;
    endtask : pins
endmodule : duc_host_model

// File: test_duc_core.sv
// Self-checking bench for the converter control core
`timescale 1ns/100ps
module test_duc_core;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic bip, vs, io, cv, ld_n, cl_n, rv, zero, ten, flt, foe;
    logic [7:0] cc;
    logic [15:0] cd, rd, act, outc, last, a, c, f;
    logic [9:0] tv;
    logic [15:0] exp_q[$];
    int fails = 0;
    int n_checks = 0;
    always #12.5 clk = ~clk;
    duc_host_model HOST (.clk_in(clk), .cmd_valid_out(cv), .cmd_code_out(cc),
        .cmd_data_out(cd), .load_n_out(ld_n), .clear_n_out(cl_n));
    duc_core DUT (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CMD_VALID_IN(cv), .CMD_CODE_IN(cc),
        .CMD_DATA_IN(cd), .BIPOLAR_IN(bip), .LOAD_STROBE_N_IN(ld_n), .ASYNC_CLEAR_N_IN(cl_n),
        .VOUT_SHORT_IN(vs), .IOUT_OPEN_IN(io), .READ_DATA_OUT(rd), .READ_VALID_OUT(rv),
        .ACTIVE_CODE_OUT(act), .ZERO_STATE_OUT(zero), .OUTPUT_CODE_OUT(outc),
        .TRIM_ENABLE_OUT(ten), .TRIM_VALUE_OUT(tv), .FAULT_OUT(flt), .FAULT_OE_OUT(foe));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %0t got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask : chk
    task automatic cmd(input logic [7:0] code, input logic [15:0] data, input logic [15:0] e);
        exp_q.push_back(e);
        last = e;
        HOST.send(code, data);
    endtask : cmd
    task automatic settle;
        repeat (8) @(negedge clk);
    endtask : settle
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    always @(negedge clk) begin
        if (rv === 1'b1 && exp_q.size() > 0) chk(rd, exp_q.pop_front());
        else if (rv === 1'b1) chk(rd, ~rd);
    end
    initial begin
        #2000000;
        fails++;
        report_and_stop;
    end
    initial begin
        vs = 1'b0;
        io = 1'b0;
        last = 16'h0000;
        bip = 1'($urandom(32'hE94AD2F1));
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        cmd(8'h07, 16'h0000, bip ? 16'h8000 : 16'h0000);
        cmd(8'h08, 16'h0000, 16'h0000);
        cmd(8'h09, 16'h0000, bip ? 16'h8000 : 16'h0000);
        a = 16'($urandom);
        cmd(8'h03, a, last);
        chk(outc, 16'h0000);
        cmd(8'h07, 16'h0000, a);
        cmd(8'h05, 16'($urandom), last);
        chk(outc, a);
        chk(act, a);
        cmd(8'h04, ~a, last);
        cmd(8'h08, 16'h0000, ~a);
        cmd(8'h00, 16'($urandom), last);
        cmd(8'h0F, 16'($urandom), last);
        c = 16'($urandom);
        cmd(8'h06, c, last);
        chk({ten, 5'h00, tv}, {c[15], 5'h00, c[9], ~c[8:0]});
        cmd(8'h09, 16'h0000, c);
        f = 16'($urandom);
        cmd(8'h03, f, last);
        HOST.pins(1'b0, 1'b1);
        settle;
        chk(outc, f);
        cmd(8'h03, ~f, last);
        settle;
        chk(outc, ~f);
        HOST.pins(1'b1, 1'b0);
        cmd(8'h01, 16'h0120, last);
        settle;
        chk(act, c);
        chk({15'h0000, foe}, 16'h0001);
        cmd(8'h02, 16'h0000, 16'h0124);
        cmd(8'h01, 16'h0320, last);
        settle;
        chk({act[15:1], foe}, {f[15:1] ^ 15'h7FFF, 1'b0});
        cmd(8'h02, 16'h0000, 16'h0320);
        cmd(8'h01, 16'h00A0, last);
        settle;
        chk({act[15:1], zero}, 16'h0001);
        HOST.pins(1'b1, 1'b1);
        settle;
        chk({15'h0000, zero}, 16'h0001);
        cmd(8'h05, 16'h0000, last);
        settle;
        chk(act, ~f);
        cmd(8'h01, 16'h0040, last);
        vs = 1'b1;
        settle;
        chk({15'h0000, foe}, 16'h0001);
        cmd(8'h02, 16'h0000, 16'h0050);
        vs = 1'b0;
        io = 1'b1;
        settle;
        cmd(8'h02, 16'h0000, 16'h0048);
        chk({15'h0000, foe}, 16'h0001);
        io = 1'b0;
        settle;
        chk({15'h0000, foe}, 16'h0000);
        repeat (20) if (exp_q.size() != 0) @(negedge clk);
        if (exp_q.size() != 0) fails++;
        report_and_stop;
    end
endmodule : test_duc_core
